// ==== hw/ahi_top.sv ====
`timescale 1ns/1ns
`include "ahi_regs.svh"
module ahi_top #(
   parameter int W        = 12,
   parameter int CFG_W    = 8,
   parameter int INT_DIV  = `AHI_INT_DIV,
   parameter int ACQ_TICK = `AHI_ACQ_TICKS
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             cs_n,
   input  wire logic             rd_n,
   input  wire logic             wr_n,
   input  wire logic             conv_clk_pin,
   input  wire logic             cmp_in,
   input  wire logic [CFG_W-1:0] parallel_data_lines_in,
   output logic      [W-1:0]     parallel_data_lines_out,
   output logic      [W-1:0]     parallel_data_lines_oe,
   output logic                  done_n,
   output logic                  track_en,
   output logic      [W-1:0]     dac_code,
   output ahi_pkg::ahi_pwr_t     power_clock_mode_field
);
   import ahi_pkg::*;

   localparam int NP = `AHI_PIN_DATA + CFG_W;

   if (W != 12 || CFG_W != 8) begin : g_chk_bus
      $error("ahi_top: bus widths fixed at 12 and 8");
   end
   // Comparator feedback needs five cycles through the pin synchroniser
   if (INT_DIV < 5 || ACQ_TICK < 1) begin : g_chk_cnt
      $error("ahi_top: pacing too fast or acquisition count zero");
   end

   ahi_conv_if #(.W(W)) cv ();
   ahi_sar #(.W(W)) u_sar (.clk(clk), .srst(srst), .cv(cv));

   // Pin synchroniser, a change counts once stages two and three agree
   logic [NP-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
   logic [3:0]    prev_ff;
   logic [NP-1:0] pins;
   assign pins = {parallel_data_lines_in, cmp_in, conv_clk_pin, wr_n, rd_n, cs_n};

   for (genvar i = 0; i < NP; i++) begin : g_flt
      assign nxt_flt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flt_ff[i];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_ff   <= '1;
         s2_ff   <= '1;
         s3_ff   <= '1;
         flt_ff  <= '1;
         prev_ff <= 4'hF;
      end else begin
         s1_ff   <= pins;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         flt_ff  <= nxt_flt;
         prev_ff <= flt_ff[3:0];
      end
   end

   logic             cs_lo, rd_lo, rd_fall, wr_rise, ext_fall;
   logic [CFG_W-1:0] bus_byte;
   assign cs_lo    = !flt_ff[`AHI_PIN_CS];
   assign rd_lo    = !flt_ff[`AHI_PIN_RD];
   assign rd_fall  = cs_lo && rd_lo && prev_ff[`AHI_PIN_RD];
   assign wr_rise  = cs_lo && flt_ff[`AHI_PIN_WR] && !prev_ff[`AHI_PIN_WR];
   assign ext_fall = !flt_ff[`AHI_PIN_CLK] && prev_ff[`AHI_PIN_CLK];
   assign bus_byte = flt_ff[NP-1:`AHI_PIN_DATA];

   // Control state
   ahi_state_t                      st_ff,   nxt_st;
   logic [CFG_W-1:0]                cfg_ff,  nxt_cfg;
   ahi_pwr_t                        pwr_ff,  nxt_pwr;
   logic                            ext_clk_ff, nxt_ext_clk;
   logic [$clog2(INT_DIV+1)-1:0]    div_ff,  nxt_div;
   logic [$clog2(ACQ_TICK+1)-1:0]   acq_ff,  nxt_acq;
   logic                            tick_ff, nxt_tick;
   logic                            start_ff, nxt_start;
   logic                            trk_ff,  nxt_trk;
   logic                            done_n_ff, nxt_done_n;
   logic [W-1:0]                    dout_ff, nxt_dout;
   logic [W-1:0]                    oe_ff,   nxt_oe;
   logic                            acq_ext;

   assign acq_ext = cfg_ff[`AHI_CFG_ACQ_EXT];
   always_comb begin
      nxt_st      = st_ff;
      nxt_cfg     = cfg_ff;
      nxt_pwr     = pwr_ff;
      nxt_ext_clk = ext_clk_ff;
      nxt_acq     = acq_ff;
      nxt_start   = 1'b0;
      nxt_div     = (div_ff == ($bits(div_ff))'(INT_DIV - 1)) ? '0 : div_ff + 1'b1;
      // Internal pacing runs free but restarts at start; external pacing uses the pin's falling edge
      nxt_tick    = ext_clk_ff ? ext_fall : (div_ff == ($bits(div_ff))'(INT_DIV - 1));
      unique case (st_ff)
         AHI_IDLE: begin
            if (wr_rise) begin
               nxt_cfg = bus_byte;
               nxt_pwr = ahi_pwr_t'(bus_byte[`AHI_CFG_PD_HI:`AHI_CFG_PD_LO]);
               if (bus_byte[`AHI_CFG_PD_HI]) begin
                  nxt_ext_clk = bus_byte[`AHI_CFG_PD_LO];
                  nxt_st      = AHI_ACQ;
                  nxt_acq     = '0;
               end
            end
         end
         AHI_ACQ: begin
            if (acq_ext) begin
               if (wr_rise) begin
                  nxt_st    = AHI_CONV;
                  nxt_start = 1'b1;
               end
            end else if (tick_ff) begin
               nxt_acq = acq_ff + 1'b1;
               if (acq_ff == ($bits(acq_ff))'(ACQ_TICK - 1)) begin
                  nxt_st    = AHI_CONV;
                  nxt_start = 1'b1;
               end
            end
         end
         AHI_CONV: begin
            if (cv.done) nxt_st = AHI_IDLE;
         end
         default: nxt_st = AHI_IDLE;
      endcase
      // Restart internal pacing at start, else the first decision may see a stale comparator
      if (nxt_start) nxt_div = '0;
      nxt_trk = (nxt_st == AHI_ACQ);
      // Done set wins over a read that clears it in the same cycle
      nxt_done_n = done_n_ff;
      if (rd_fall) nxt_done_n = 1'b1;
      if (cv.done) nxt_done_n = 1'b0;
      // Drive only with select and read both low; all twelve lines
      nxt_oe   = (cs_lo && rd_lo) ? '1 : '0;
      nxt_dout = (cs_lo && rd_lo) ? cv.result : '0;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff      <= AHI_IDLE;
         cfg_ff     <= `AHI_CFG_RESET;
         pwr_ff     <= AHI_PWR_NORM_INT;
         ext_clk_ff <= 1'b0;
         div_ff     <= '0;
         acq_ff     <= '0;
         tick_ff    <= 1'b0;
         start_ff   <= 1'b0;
         trk_ff     <= 1'b0;
         done_n_ff  <= 1'b1;
         dout_ff    <= '0;
         oe_ff      <= '0;
      end else begin
         st_ff      <= nxt_st;
         cfg_ff     <= nxt_cfg;
         pwr_ff     <= nxt_pwr;
         ext_clk_ff <= nxt_ext_clk;
         div_ff     <= nxt_div;
         acq_ff     <= nxt_acq;
         tick_ff    <= nxt_tick;
         start_ff   <= nxt_start;
         trk_ff     <= nxt_trk;
         done_n_ff  <= nxt_done_n;
         dout_ff    <= nxt_dout;
         oe_ff      <= nxt_oe;
      end
   end

   assign cv.start = start_ff;
   assign cv.tick  = tick_ff && (st_ff == AHI_CONV);
   assign cv.cmp   = flt_ff[`AHI_PIN_CMP];

   assign parallel_data_lines_out = dout_ff;
   assign parallel_data_lines_oe  = oe_ff;
   assign done_n                  = done_n_ff;
   assign track_en                = trk_ff;
   assign dac_code                = cv.dac;
   assign power_clock_mode_field  = pwr_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_DONE_LOW: assert property (cv.done |=> !done_n_ff)
      else $error("done not signalled after conversion");
   AST_RD_CLEARS: assert property (rd_fall && !cv.done |=> done_n_ff)
      else $error("read did not clear done");
   AST_READ_DRIVES: assert property (rd_fall |=> oe_ff == '1 && dout_ff == $past(cv.result))
      else $error("read did not present result");
   AST_CS_RELEASE: assert property (!cs_lo |=> oe_ff == '0)
      else $error("bus driven with select high");
   AST_OE_QUAL: assert property (oe_ff != '0 |-> $past(cs_lo) && $past(rd_lo))
      else $error("bus driven outside read window");
   AST_CFG_CAPTURE: assert property (st_ff == AHI_IDLE && wr_rise |=> cfg_ff == $past(bus_byte))
      else $error("config byte not captured");
   AST_INT_ACQ: assert property (st_ff == AHI_IDLE && wr_rise && bus_byte[7]
      |=> st_ff == AHI_ACQ ##1 trk_ff)
      else $error("write did not start acquisition");
   AST_EXT_END: assert property (st_ff == AHI_ACQ && acq_ext && wr_rise
      |=> st_ff == AHI_CONV && start_ff ##1 !trk_ff)
      else $error("external acquisition not ended by write");
   AST_PD_HOLD: assert property (st_ff == AHI_IDLE && wr_rise && !bus_byte[7]
      |=> st_ff == AHI_IDLE && ext_clk_ff == $past(ext_clk_ff))
      else $error("power-down code started a conversion");
   AST_INT_ACQ_LEN: assert property (st_ff == AHI_ACQ && !acq_ext
      |-> acq_ff <= ($bits(acq_ff))'(ACQ_TICK - 1))
      else $error("internal acquisition overran");

   COV_CONV: cover property (start_ff ##[1:1000] cv.done);
   COV_READ: cover property (!done_n_ff ##[1:100] rd_fall);
   COV_EXT:  cover property (st_ff == AHI_ACQ && acq_ext && wr_rise);
endmodule : ahi_top

// ==== hw/ahi_regs.svh ====
`ifndef AHI_REGS_SVH
`define AHI_REGS_SVH

`define AHI_CFG_PD_HI       7
`define AHI_CFG_PD_LO       6
`define AHI_CFG_ACQ_EXT     5
`define AHI_CFG_RESET       8'h80

`define AHI_CLK_PERIOD_NS   8
`define AHI_INT_CLK_NS      208
`define AHI_INT_DIV         (`AHI_INT_CLK_NS / `AHI_CLK_PERIOD_NS)
`define AHI_ACQ_TICKS       6

`define AHI_PIN_CS          0
`define AHI_PIN_RD          1
`define AHI_PIN_WR          2
`define AHI_PIN_CLK         3
`define AHI_PIN_CMP         4
`define AHI_PIN_DATA        5

`endif

// ==== hw/ahi_pkg.sv ====
package ahi_pkg;
   typedef enum logic [1:0] {
      AHI_IDLE = 2'b00,
      AHI_ACQ  = 2'b01,
      AHI_CONV = 2'b11
   } ahi_state_t;

   typedef enum logic [1:0] {
      AHI_PWR_FULL_DOWN = 2'b00,
      AHI_PWR_STANDBY   = 2'b01,
      AHI_PWR_NORM_INT  = 2'b10,
      AHI_PWR_NORM_EXT  = 2'b11
   } ahi_pwr_t;
endpackage : ahi_pkg

// ==== hw/ahi_conv_if.sv ====
`timescale 1ns/1ns
interface ahi_conv_if #(parameter int W = 12);
   logic         start;
   logic         tick;
   logic         cmp;
   logic         done;
   logic [W-1:0] result;
   logic [W-1:0] dac;

   modport ctl (output start, output tick, output cmp, input done, input result, input dac);
   modport eng (input start, input tick, input cmp, output done, output result, output dac);
endinterface : ahi_conv_if

// ==== hw/ahi_sar.sv ====
`timescale 1ns/1ns
module ahi_sar #(
   parameter int W = 12
) (
   input  wire logic clk,
   input  wire logic srst,
   ahi_conv_if.eng   cv
);
   import ahi_pkg::*;

   logic [W-1:0]         code_ff,   nxt_code;
   logic [W-1:0]         result_ff, nxt_result;
   logic [$clog2(W)-1:0] idx_ff,    nxt_idx;
   logic                 busy_ff,   nxt_busy;
   logic                 done_ff,   nxt_done;

   if (W < 2) begin : g_chk_w
      $error("ahi_sar: width too small");
   end

   // One decision per conversion tick, top bit first
   always_comb begin
      nxt_code   = code_ff;
      nxt_result = result_ff;
      nxt_idx    = idx_ff;
      nxt_busy   = busy_ff;
      nxt_done   = 1'b0;
      if (cv.start) begin
         nxt_code = '0;
         nxt_code[W-1] = 1'b1;
         nxt_idx  = $clog2(W)'(W-1);
         nxt_busy = 1'b1;
      end else if (busy_ff && cv.tick) begin
         if (!cv.cmp) nxt_code[idx_ff] = 1'b0;
         if (idx_ff == '0) begin
            nxt_busy   = 1'b0;
            nxt_done   = 1'b1;
            nxt_result = cv.cmp ? code_ff : (code_ff & ~(W'(1) << idx_ff));
         end else begin
            nxt_idx = idx_ff - 1'b1;
            nxt_code[idx_ff - 1'b1] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         code_ff   <= '0;
         result_ff <= '0;
         idx_ff    <= '0;
         busy_ff   <= 1'b0;
         done_ff   <= 1'b0;
      end else begin
         code_ff   <= nxt_code;
         result_ff <= nxt_result;
         idx_ff    <= nxt_idx;
         busy_ff   <= nxt_busy;
         done_ff   <= nxt_done;
      end
   end

   assign cv.done   = done_ff;
   assign cv.result = result_ff;
   assign cv.dac    = code_ff;

   AST_SAR_DONE_ENDS_BUSY: assert property (@(posedge clk) disable iff (srst)
      done_ff |-> !busy_ff && $past(busy_ff) && $past(idx_ff) == '0)
      else $error("sar done without final step");
endmodule : ahi_sar

// ==== verif/ahi_host_model.sv ====
`timescale 1ns/1ns
module ahi_host_model (
   input  wire logic       clk,
   input  wire logic       ext_clk_en,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic            conv_clk_pin,
   output logic      [7:0] hd
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      conv_clk_pin = 1'b0;
      hd = 8'hA5;
   end
   // Runs only in external clock mode, else parked static
   always begin
      #40;
      if (ext_clk_en) conv_clk_pin = ~conv_clk_pin;
   end
   task automatic wr_cfg(input logic [7:0] cfg);
      @(negedge clk);
      cs_n = 1'b0;
      hd   = cfg;
      wr_n = 1'b0;
      repeat (6) @(negedge clk);
      wr_n = 1'b1;
      repeat (6) @(negedge clk);
      cs_n = 1'b1;
      // Released lines have no pull: show a changed level
      hd   = ~cfg;
   endtask : wr_cfg
   task automatic rd_set(input logic cs, input logic rd);
      @(negedge clk);
      cs_n = cs;
      rd_n = rd;
      repeat (8) @(negedge clk);
   endtask : rd_set
endmodule : ahi_host_model

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
   import ahi_pkg::*;
   logic            clk = 1'b0;
   logic            srst = 1'b1;
   logic            ext_clk_en = 1'b0;
   logic            cs_n, rd_n, wr_n, conv_clk_pin;
   logic      [7:0] hd;
   logic      [7:0] din;
   logic     [11:0] dout, doe, dac_code;
   logic     [11:0] target = 12'hA5C;
   logic            cmp_bit;
   logic            done_n, track_en;
   ahi_pwr_t        mode;
   int              err_count = 0;
   int              cmp_count = 0;
   int              cyc = 0;
   always #4 clk = ~clk;
   // Wire level: device drive wins, else the host
   assign din = doe[0] ? dout[7:0] : hd;
   // Ideal comparator: keep the trial bit while the code does not exceed the input
   assign cmp_bit = (dac_code <= target);
   ahi_host_model host (.clk(clk), .ext_clk_en(ext_clk_en), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .conv_clk_pin(conv_clk_pin), .hd(hd));
   ahi_top #(.INT_DIV(8)) DUT (.clk(clk), .srst(srst), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .conv_clk_pin(conv_clk_pin),
      .cmp_in(cmp_bit), .parallel_data_lines_in(din),
      .parallel_data_lines_out(dout), .parallel_data_lines_oe(doe), .done_n(done_n),
      .track_en(track_en), .dac_code(dac_code), .power_clock_mode_field(mode));
   task automatic close_out();
      $display("cmp_count=%0d err_count=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wait_done();
      for (int i = 0; i < 600 && done_n !== 1'b0; i++) @(negedge clk);
      chk("done_n low", done_n, 16'h0);
   endtask : wait_done
   task automatic read_check();
      chk("dac final", dac_code, target);
      host.rd_set(1'b0, 1'b1);
      host.rd_set(1'b0, 1'b0);
      chk("oe reading", doe, 16'hFFF);
      chk("result", dout, target);
      chk("done_n cleared", done_n, 16'h1);
      host.rd_set(1'b0, 1'b1);
      chk("oe after rd", doe, 16'h0);
      host.rd_set(1'b1, 1'b1);
   endtask : read_check
   task automatic t_reset();
      chk("oe reset", doe, 16'h0);
      chk("done_n reset", done_n, 16'h1);
      chk("track reset", track_en, 16'h0);
      chk("mode reset", mode, AHI_PWR_NORM_INT);
   endtask : t_reset
   task automatic t_int_conv();
      target = 12'hA5C;
      host.wr_cfg(8'h80);
      wait_done();
      chk("mode int", mode, AHI_PWR_NORM_INT);
      read_check();
   endtask : t_int_conv
   task automatic t_power_down();
      logic [7:0] codes [2] = '{8'h00, 8'h40};
      foreach (codes[i]) begin
         host.wr_cfg(codes[i]);
         repeat (200) @(negedge clk);
         chk("pd no start", track_en, 16'h0);
         chk("pd no done", done_n, 16'h1);
         chk("pd mode", mode, codes[i][7:6]);
      end
   endtask : t_power_down
   task automatic t_ext_clk();
      target = 12'h3F1;
      ext_clk_en = 1'b1;
      host.wr_cfg(8'hC0);
      chk("mode ext", mode, AHI_PWR_NORM_EXT);
      wait_done();
      read_check();
      ext_clk_en = 1'b0;
   endtask : t_ext_clk
   task automatic t_ext_acq();
      target = 12'h001;
      host.wr_cfg(8'hA0);
      // Far beyond the internal sampling time
      repeat (100) @(negedge clk);
      chk("ext acq track", track_en, 16'h1);
      chk("ext acq no done", done_n, 16'h1);
      host.wr_cfg(8'hA0);
      wait_done();
      chk("ext acq ended", track_en, 16'h0);
      read_check();
   endtask : t_ext_acq
   task automatic t_cs_high();
      host.rd_set(1'b1, 1'b0);
      chk("oe cs high", doe, 16'h0);
      host.rd_set(1'b1, 1'b1);
   endtask : t_cs_high
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (5) @(negedge clk);
      t_reset();
      t_int_conv();
      t_power_down();
      t_ext_clk();
      t_ext_acq();
      t_cs_high();
      close_out();
   end
endmodule : tb
